// *** evd_pkg.sv ***
// Constants and types for the exception vector dispatch block.
// Assumes one core clock domain; all users import the whole package.
package evd_pkg;

  // ****************************************************************
  // Interrupt slots and vector indices
  // ****************************************************************
  localparam int NSLOT  = 19;
  localparam int SL_CI  = 0;
  localparam int SL_MC  = 1;
  localparam int SL_EXT = 4;
  localparam int SL_PRG = 6;
  localparam int SL_DEC = 10;
  localparam int SL_FIT = 11;
  localparam int SL_WD  = 12;
  localparam int SL_DBG = 15;
  // Architected vector offset register index of each slot
  localparam logic [5:0] VIDX [NSLOT] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04,
    6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e,
    6'h0f, 6'h20, 6'h21, 6'h22};
  // Highest priority first
  localparam logic [4:0] PRIO [NSLOT] = '{5'h01, 5'h00, 5'h0c, 5'h0f,
    5'h03, 5'h0e, 5'h02, 5'h0d, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h10,
    5'h11, 5'h12, 5'h04, 5'h0b, 5'h0a};

  // ****************************************************************
  // Machine state fields and reset values
  // ****************************************************************
  localparam int MS_DS  = 4;
  localparam int MS_IS  = 5;
  localparam int MS_FE1 = 8;
  localparam int MS_DE  = 9;
  localparam int MS_FE0 = 11;
  localparam int MS_ME  = 12;
  localparam int MS_FP  = 13;
  localparam int MS_PR  = 14;
  localparam int MS_EE  = 15;
  localparam int MS_CE  = 17;
  localparam int MS_WE  = 18;
  localparam int MS_SPE = 25;
  localparam logic [31:0] MS_RESET = 32'h0000_0000;
  localparam logic [15:0] PREFIX_RESET = 16'h0000;
  localparam logic [11:0] VO_RESET = 12'h000;

  // ****************************************************************
  // Syndrome fields and per-slot masks
  // ****************************************************************
  localparam int SY_ST = 0;
  localparam int SY_FP = 1;
  localparam int SY_AP = 2;
  localparam int SY_BO = 4;
  localparam logic [7:0] SY_RESET = 8'h00;
  localparam logic [7:0] SY_ALLOW [NSLOT] = '{8'h00, 8'h00, 8'h1f, 8'h10,
    8'h00, 8'h0f, 8'he6, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] SY_FORCE_ISI = 8'h10;
  localparam int SL_ISI = 3;

  // Debug event bits
  localparam logic [7:0] DBS_RESET = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic crit;
    logic async;
    logic sprec;
    logic simpr;
  } evd_class_type;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_SETTLE = 2'b10
  } evd_state_type;

endpackage

// *** evd_core.sv ***
// Exception vector dispatch: gating, priority, save state, vectoring.
// Assumes requests other than the critical pin come from core-clock logic.
`timescale 1ns/1ps

module evd_core
  import evd_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 nrst_i,
  input  wire logic                 ce_i,
  input  wire logic                 crit_in_i,
  input  wire logic [NSLOT-1:0]     exc_req_i,
  input  wire logic                 fp_enabled_exc_i,
  input  wire logic                 decrementer_int_enable_i,
  input  wire logic                 fixed_interval_int_enable_i,
  input  wire logic                 watchdog_int_enable_i,
  input  wire logic                 internal_debug_mode_i,
  input  wire logic [7:0]           dbg_evt_i,
  input  wire logic [7:0]           dbg_clr_i,
  input  wire logic [7:0]           syndrome_i,
  input  wire logic [31:0]          next_pc_i,
  input  wire logic [31:0]          fault_pc_i,
  input  wire logic                 ms_we_i,
  input  wire logic [31:0]          ms_wdata_i,
  input  wire logic                 prefix_we_i,
  input  wire logic [15:0]          prefix_i,
  input  wire logic                 vo_we_i,
  input  wire logic [5:0]           vo_idx_i,
  input  wire logic [11:0]          vo_data_i,
  input  wire logic                 rfi_i,
  input  wire logic                 rfci_i,
  output logic                      take_o,
  output logic [4:0]                take_slot_o,
  output evd_class_type             class_o,
  output logic                      fetch_valid_o,
  output logic [31:0]               fetch_addr_o,
  output logic [31:0]               machine_state_o,
  output logic [31:0]               save_pc_o,
  output logic [31:0]               save_state_o,
  output logic [31:0]               crit_save_pc_o,
  output logic [31:0]               crit_save_state_o,
  output logic [7:0]                syndrome_o,
  output logic [7:0]                debug_status_o,
  output logic [1:0]                fp_prec_o
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Pick the highest-priority enabled slot; scanned high to low so the last match, the first entry, wins
  function automatic logic [4:0] pick_fn(input logic [NSLOT-1:0] en);
    logic [4:0] sel;
    sel = 5'h00;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (en[PRIO[i]]) begin
        sel = PRIO[i];
      end
    end
    return sel;
  endfunction

  // Critical class: critical input, machine check, watchdog, debug
  function automatic logic crit_fn(input logic [4:0] s);
    return (s == 5'(SL_CI)) || (s == 5'(SL_MC)) || (s == 5'(SL_WD))
        || (s == 5'(SL_DBG));
  endfunction

  // Asynchronous class: pin and timer driven types
  function automatic logic async_fn(input logic [4:0] s);
    return (s == 5'(SL_CI)) || (s == 5'(SL_EXT)) || (s == 5'(SL_DEC))
        || (s == 5'(SL_FIT)) || (s == 5'(SL_WD));
  endfunction

  // New machine state on taking slot s
  function automatic logic [31:0] ms_fn(input logic [31:0] ms, input logic [4:0] s);
    logic [31:0] clr;
    clr = '0;
    clr[MS_SPE] = 1'b1;
    clr[MS_WE]  = 1'b1;
    clr[MS_EE]  = 1'b1;
    clr[MS_PR]  = 1'b1;
    clr[MS_FP]  = 1'b1;
    clr[MS_FE0] = 1'b1;
    clr[MS_FE1] = 1'b1;
    clr[MS_IS]  = 1'b1;
    clr[MS_DS]  = 1'b1;
    if (crit_fn(s)) begin
      clr[MS_CE] = 1'b1;
      clr[MS_DE] = 1'b1;
    end
    if (s == 5'(SL_MC)) begin
      clr[MS_ME] = 1'b1;
    end
    if (s == 5'(SL_CI)) begin
      clr = ~(32'h1 << MS_ME);
    end
    return ms & ~clr;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  evd_state_type state_q;
  logic          ci_s1_q;
  logic          ci_s2_q;
  logic          ci_latch_q;
  logic [11:0]   vo_q [NSLOT];
  logic [15:0]   prefix_q;
  logic [31:0]   ms_q;
  logic [7:0]    dbs_q;
  logic [4:0]    slot_q;
  logic          take_q;
  logic          fv_q;
  logic [31:0]   fa_q;
  logic [31:0]   spc_q;
  logic [31:0]   sst_q;
  logic [31:0]   cpc_q;
  logic [31:0]   cst_q;
  logic [7:0]    syn_q;
  evd_class_type cls_q;

  // ****************************************************************
  // Gating and selection
  // ****************************************************************

  // Mode bits and derived qualifiers
  wire logic            ce_w     = ms_q[MS_CE];
  wire logic            ee_w     = ms_q[MS_EE];
  wire logic            dbg_ok_w = ms_q[MS_DE] & internal_debug_mode_i;
  wire logic [1:0]      fpm_w    = {ms_q[MS_FE0], ms_q[MS_FE1]};
  wire logic            ci_w     = ((ci_s2_q & ce_w) | ci_latch_q) & ce_w;
  wire logic            fpx_w    = fp_enabled_exc_i & (fpm_w != 2'b00);
  wire logic [NSLOT-1:0] en_w;
  wire logic            any_w    = |en_w;
  wire logic [4:0]      sel_w    = pick_fn(en_w);
  wire logic            go_w     = (state_q == ST_IDLE) & any_w;
  wire logic            rfi_go_w = (state_q == ST_IDLE) & ~any_w & rfi_i;
  wire logic            rfci_go_w = (state_q == ST_IDLE) & ~any_w & ~rfi_i & rfci_i;
  wire logic [31:0]     pc_w     = async_fn(sel_w) ? next_pc_i : fault_pc_i;
  wire logic [7:0]      sy_w     = (syndrome_i & SY_ALLOW[sel_w])
                                 | ((sel_w == 5'(SL_ISI)) ? SY_FORCE_ISI : 8'h00);
  wire logic [7:0]      syx_w    = sy_w & ~(sy_w[SY_FP] ? (8'h1 << SY_AP) : 8'h00);
  wire logic [7:0]      dbs_d    = (dbs_q & ~dbg_clr_i) | (dbg_evt_i & {8{dbg_ok_w}});

  // Per-type enables; unlisted types are unmaskable here
  assign en_w = {exc_req_i[NSLOT-1:SL_DBG+1],
                 (|dbs_q) & dbg_ok_w,
                 exc_req_i[SL_DBG-1:SL_WD+1],
                 exc_req_i[SL_WD] & ce_w & watchdog_int_enable_i,
                 exc_req_i[SL_FIT] & ee_w & fixed_interval_int_enable_i,
                 exc_req_i[SL_DEC] & ee_w & decrementer_int_enable_i,
                 exc_req_i[SL_DEC-1:SL_PRG+1],
                 exc_req_i[SL_PRG] | fpx_w,
                 exc_req_i[SL_PRG-1:SL_EXT+1],
                 exc_req_i[SL_EXT] & ee_w,
                 exc_req_i[SL_EXT-1:SL_MC+1],
                 exc_req_i[SL_MC] & ms_q[MS_ME],
                 ci_w};

  // Outputs straight from registers
  assign take_o            = take_q;
  assign take_slot_o       = slot_q;
  assign class_o           = cls_q;
  assign fetch_valid_o     = fv_q;
  assign fetch_addr_o      = fa_q;
  assign machine_state_o   = ms_q;
  assign save_pc_o         = spc_q;
  assign save_state_o      = sst_q;
  assign crit_save_pc_o    = cpc_q;
  assign crit_save_state_o = cst_q;
  assign syndrome_o        = syn_q;
  assign debug_status_o    = dbs_q;
  assign fp_prec_o         = fpm_w; // 00 off, 01/10 imprecise, 11 precise

  // ****************************************************************
  // Pin synchroniser and critical input latch
  // ****************************************************************

  // The pin is asynchronous; only the second stage feeds logic. assumed held.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ci_s1_q    <= 1'b0;
      ci_s2_q    <= 1'b0;
      ci_latch_q <= 1'b0;
    end else if (ce_i) begin
      ci_s1_q    <= crit_in_i;
      ci_s2_q    <= ci_s1_q;
      // The synced pin still reads high on the take cycle. That is the same request,
      // so the take clears the latch. Otherwise a later enable would dispatch it twice.
      ci_latch_q <= ((ci_s2_q & ce_w) | ci_latch_q)
                    & ~(go_w & sel_w == 5'(SL_CI));
    end
  end

  // ****************************************************************
  // Software-written vector registers
  // ****************************************************************

  // Writes to unassigned indices are dropped
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prefix_q <= PREFIX_RESET;
      for (int i = 0; i < NSLOT; i++) vo_q[i] <= VO_RESET;
    end else if (ce_i) begin
      if (prefix_we_i) prefix_q <= prefix_i;
      for (int i = 0; i < NSLOT; i++) begin
        if (vo_we_i && vo_idx_i == VIDX[i]) vo_q[i] <= vo_data_i;
      end
    end
  end

  // ****************************************************************
  // Dispatch state machine
  // ****************************************************************

  // A settle cycle lets the new machine state gate the next decision
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      take_q  <= 1'b0;
      fv_q    <= 1'b0;
      slot_q  <= 5'h00;
    end else if (ce_i) begin
      take_q <= go_w;
      fv_q   <= go_w | rfi_go_w | rfci_go_w;
      case (state_q)
        ST_IDLE: begin
          if (go_w) begin
            state_q <= ST_SETTLE;
            slot_q  <= sel_w;
          end
        end
        ST_SETTLE: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Save registers, machine state, syndrome, fetch address
  // ****************************************************************

  // Taking an interrupt wins over returns and software writes
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ms_q  <= MS_RESET;
      fa_q  <= '0;
      spc_q <= '0;
      sst_q <= MS_RESET;
      cpc_q <= '0;
      cst_q <= MS_RESET;
      syn_q <= SY_RESET;
      cls_q <= '0;
    end else if (ce_i) begin
      if (go_w) begin
        ms_q  <= ms_fn(ms_q, sel_w);
        fa_q  <= {prefix_q, vo_q[sel_w], 4'h0};
        cls_q <= '{crit:  crit_fn(sel_w),
                   async: async_fn(sel_w),
                   sprec: ~async_fn(sel_w) & (sel_w != 5'(SL_MC))
                          & ~(sel_w == 5'(SL_PRG) & fpx_w & fpm_w != 2'b11),
                   simpr: sel_w == 5'(SL_PRG) & fpx_w & fpm_w != 2'b11};
        if (crit_fn(sel_w)) begin
          cpc_q <= pc_w;
          cst_q <= ms_q;
        end else begin
          spc_q <= pc_w;
          sst_q <= ms_q;
        end
        if (SY_ALLOW[sel_w] != 8'h00) syn_q <= syx_w;
      end else if (rfi_go_w) begin
        ms_q <= sst_q;
        fa_q <= spc_q;
      end else if (rfci_go_w) begin
        ms_q <= cst_q;
        fa_q <= cpc_q;
      end else if (ms_we_i) begin
        ms_q <= ms_wdata_i;
      end
    end
  end

  // Debug status: a new event wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) dbs_q <= DBS_RESET;
    else if (ce_i) dbs_q <= dbs_d;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // Enable history for the checks; a take frozen by a low enable must not count again
  logic ce_past_q;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) ce_past_q <= 1'b0;
    else ce_past_q <= ce_i;
  end

  wire logic tk_w  = take_q & ce_past_q;
  wire logic tci_w = tk_w & (slot_q == 5'(SL_CI));

  ci_enable_a: assert property (tci_w |-> $past(ms_q[MS_CE]))
    else $error("critical input taken while disabled");
  ci_state_a: assert property (tci_w |-> ms_q == ($past(ms_q) & (32'h1 << MS_ME)))
    else $error("critical input state update wrong");
  ci_save_pc_a: assert property (tci_w |-> cpc_q == $past(next_pc_i))
    else $error("critical save pc wrong");
  ci_save_ms_a: assert property (tci_w |-> cst_q == $past(ms_q))
    else $error("critical save state wrong");
  vec_addr_a: assert property (tk_w |-> fa_q == {$past(prefix_q), vo_q[slot_q], 4'h0})
    else $error("vector address wrong");
  ext_gate_a: assert property (tk_w && (slot_q == 5'(SL_EXT) || slot_q == 5'(SL_DEC)
    || slot_q == 5'(SL_FIT)) |-> $past(ms_q[MS_EE]))
    else $error("external-class interrupt taken while masked");
  dbg_quiet_a: assert property (ce_i && !dbg_ok_w |=> (dbs_q & ~$past(dbs_q)) == 8'h00)
    else $error("debug status set while debug disabled");
  one_take_a: assert property (take_q && ce_i |=> !take_q)
    else $error("back to back dispatch");
  syn_excl_a: assert property (!(syn_q[SY_FP] && syn_q[SY_AP]))
    else $error("exclusive syndrome pair both set");
  rfi_back_a: assert property (rfi_go_w && ce_i |=> ms_q == $past(sst_q) && fa_q == $past(spc_q))
    else $error("return did not restore state");
  crit_pair_a: assert property (tk_w && cls_q.crit |-> spc_q == $past(spc_q))
    else $error("critical interrupt touched ordinary pair");

  ci_taken_c: cover property (tci_w);
  dbg_taken_c: cover property (tk_w && slot_q == 5'(SL_DBG));
  rfci_c: cover property (rfci_go_w && ce_i);

endmodule // evd_core

// *** evd_crit_src.sv ***
// Model of the system interrupt controller that drives the critical pin.
// Assumes the bench pulses go_i for one cycle, driven at a rising edge.
`timescale 1ns/1ps
module evd_crit_src
(
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic go_i,
  input  wire logic hold_i,
  input  wire logic taken_i,
  output logic      crit_o
);
  logic [2:0] age_q;

  // Level stays up until taken; a withdrawing source drops it early
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crit_o <= 1'b0;
      age_q  <= 3'h0;
    end else if (go_i) begin
      crit_o <= 1'b1;
      age_q  <= 3'h0;
    end else if (crit_o) begin
      age_q <= age_q + 3'h1;
      if (taken_i || (!hold_i && age_q == 3'h3)) begin
        crit_o <= 1'b0;
      end
    end
  end
endmodule // evd_crit_src

// *** test_evd_core.sv ***
// Self-checking bench for the exception vector dispatch core.
// Assumes one 200 MHz core clock; inputs change by NBA at rising edges.
`timescale 1ns/1ps
module test_evd_core;
  import evd_pkg::*;
  // ****
  // Signals
  // ****
  logic clock_i, nrst_i, ce_i, crit_in_i, fp_enabled_exc_i, rfi_i, rfci_i;
  logic decrementer_int_enable_i, fixed_interval_int_enable_i, watchdog_int_enable_i;
  logic internal_debug_mode_i, ms_we_i, prefix_we_i, vo_we_i, go, hold;
  logic [NSLOT-1:0] exc_req_i;
  logic [7:0]       dbg_evt_i, dbg_clr_i, syndrome_i, syndrome_o, debug_status_o;
  logic [31:0]      next_pc_i, fault_pc_i, ms_wdata_i, fetch_addr_o, machine_state_o;
  logic [31:0]      save_pc_o, save_state_o, crit_save_pc_o, crit_save_state_o;
  logic [15:0]      prefix_i;
  logic [5:0]       vo_idx_i;
  logic [11:0]      vo_data_i;
  logic             take_o, fetch_valid_o;
  logic [4:0]       take_slot_o;
  logic [1:0]       fp_prec_o;
  evd_class_type    class_o;
  int               n_errors, check_count, cycles;

  evd_core evd_core_i (.clock_i, .nrst_i, .ce_i, .crit_in_i, .exc_req_i, .fp_enabled_exc_i,
    .decrementer_int_enable_i, .fixed_interval_int_enable_i, .watchdog_int_enable_i,
    .internal_debug_mode_i, .dbg_evt_i, .dbg_clr_i, .syndrome_i, .next_pc_i, .fault_pc_i,
    .ms_we_i, .ms_wdata_i, .prefix_we_i, .prefix_i, .vo_we_i, .vo_idx_i, .vo_data_i, .rfi_i,
    .rfci_i, .take_o, .take_slot_o, .class_o, .fetch_valid_o, .fetch_addr_o, .machine_state_o,
    .save_pc_o, .save_state_o, .crit_save_pc_o, .crit_save_state_o, .syndrome_o,
    .debug_status_o, .fp_prec_o);

  evd_crit_src evd_crit_src_i (.clock_i, .nrst_i, .go_i(go), .hold_i(hold),
    .taken_i(take_o && take_slot_o === 5'd0), .crit_o(crit_in_i));

  // 5 ns clock, and a cycle ceiling so a hang still ends in the report
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // Bounded watch for a dispatch; leaves the caller just past an edge
  task automatic wait_take(output logic got);
    got = 1'b0;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clock_i);
      #1;
      got = (take_o === 1'b1);
    end
  endtask
  function automatic logic [31:0] va(input logic [5:0] idx);
    return {16'h00a5, 6'h2a, idx, 4'h0};
  endfunction
  task automatic ms_wr(input logic [31:0] v);
    @(posedge clock_i);
    ms_wdata_i <= v;
    ms_we_i    <= 1'b1;
    @(posedge clock_i);
    ms_we_i <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_setup();
    logic [5:0] ids [7] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h0a, 6'h0f, 6'h20};
    @(posedge clock_i);
    prefix_i    <= 16'h00a5;
    prefix_we_i <= 1'b1;
    foreach (ids[k]) begin
      @(posedge clock_i);
      prefix_we_i <= 1'b0;
      vo_idx_i    <= ids[k];
      vo_data_i   <= {6'h2a, ids[k]};
      vo_we_i     <= 1'b1;
    end
    @(posedge clock_i);
    vo_we_i <= 1'b0;
  endtask
  // External input, then return restores the saved pair
  task automatic t_ext();
    logic got;
    ms_wr(32'h0000_c000);
    @(posedge clock_i);
    next_pc_i <= 32'h0000_1000;
    exc_req_i[SL_EXT] <= 1'b1;
    wait_take(got);
    chk(got && take_slot_o === 5'd4, "external not taken");
    chk(fetch_valid_o === 1'b1 && fetch_addr_o === va(6'h04), "external vector");
    chk(save_pc_o === 32'h1000 && save_state_o === 32'hc000, "save pair");
    chk(class_o === 4'b0100 && machine_state_o === 32'h0, "external class");
    @(posedge clock_i);
    exc_req_i <= '0;
    @(posedge clock_i);
    rfi_i <= 1'b1;
    @(posedge clock_i);
    rfi_i <= 1'b0;
    #1;
    chk(fetch_addr_o === 32'h1000 && machine_state_o === 32'hc000, "return");
  endtask
  // Decrementer needs its timer enable as well as the external enable
  task automatic t_dec();
    logic got;
    ms_wr(32'h1 << MS_EE);
    @(posedge clock_i);
    exc_req_i[SL_DEC] <= 1'b1;
    wait_take(got);
    chk(got === 1'b0, "decrementer taken without enable");
    @(posedge clock_i);
    decrementer_int_enable_i <= 1'b1;
    wait_take(got);
    chk(got && take_slot_o === 5'd10, "decrementer not taken");
    @(posedge clock_i);
    exc_req_i <= '0;
    decrementer_int_enable_i <= 1'b0;
  endtask
  // Two requests together: higher first, extension type after the settle
  task automatic t_prio();
    logic got;
    @(posedge clock_i);
    fault_pc_i <= 32'h0000_2000;
    exc_req_i  <= (19'h1 << 8) | (19'h1 << 16);
    wait_take(got);
    chk(got && take_slot_o === 5'd8, "priority order");
    @(posedge clock_i);
    exc_req_i <= 19'h1 << 16;
    wait_take(got);
    chk(got && take_slot_o === 5'd16 && fetch_addr_o === va(6'h20), "index 32");
    chk(class_o === 4'b0010 && save_pc_o === 32'h2000, "extension class");
    @(posedge clock_i);
    exc_req_i <= '0;
  endtask
  // Critical pin held by the source until the core takes it
  task automatic t_crit();
    logic got;
    ms_wr(32'h0002_d000);
    @(posedge clock_i);
    next_pc_i <= 32'h0000_3000;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    wait_take(got);
    chk(got && take_slot_o === 5'd0 && class_o === 4'b1100, "critical take");
    chk(crit_save_pc_o === 32'h3000, "critical save pc");
    chk(crit_save_state_o === 32'h0002_d000, "critical save state");
    chk(machine_state_o === (32'h1 << MS_ME), "critical new state");
    chk(save_pc_o === 32'h2000 && fetch_addr_o === va(6'h00), "critical pair");
  endtask
  // Pin withdrawn while the critical enable was clear is never taken
  task automatic t_wdraw();
    logic got;
    ms_wr(32'h0);
    @(posedge clock_i);
    go   <= 1'b1;
    hold <= 1'b0;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (10) @(posedge clock_i);
    ms_wr(32'h1 << MS_CE);
    wait_take(got);
    chk(got === 1'b0, "withdrawn critical taken");
    @(posedge clock_i);
    hold <= 1'b1;
  endtask
  // Data storage with every cause offered: exclusive pair keeps one bit
  task automatic t_syn();
    logic got;
    ms_wr(32'h0);
    @(posedge clock_i);
    syndrome_i <= 8'hff;
    exc_req_i[2] <= 1'b1;
    wait_take(got);
    chk(got && syndrome_o === 8'h1b, "syndrome");
    @(posedge clock_i);
    exc_req_i <= '0;
  endtask
  // Debug events are dropped with the debug enable low
  task automatic t_dbg();
    logic got;
    @(posedge clock_i);
    internal_debug_mode_i <= 1'b1;
    dbg_evt_i <= 8'h01;
    @(posedge clock_i);
    dbg_evt_i <= 8'h00;
    wait_take(got);
    chk(got === 1'b0 && debug_status_o === 8'h00, "debug while disabled");
    ms_wr(32'h1 << MS_DE);
    @(posedge clock_i);
    dbg_evt_i <= 8'h04;
    @(posedge clock_i);
    dbg_evt_i <= 8'h00;
    wait_take(got);
    chk(got && take_slot_o === 5'd15 && class_o.crit === 1'b1, "debug take");
    chk(fetch_addr_o === va(6'h0f) && debug_status_o === 8'h04, "debug status");
    @(posedge clock_i);
    dbg_clr_i <= 8'h04;
    @(posedge clock_i);
    dbg_clr_i <= 8'h00;
    #1;
    chk(debug_status_o === 8'h00, "debug clear");
  endtask
  // Fp mode bits reach the precision select; machine check clears them
  task automatic t_mc();
    logic got;
    ms_wr((32'h1 << MS_ME) | (32'h1 << MS_FE0));
    #1;
    chk(fp_prec_o === 2'b10, "fp precision");
    @(posedge clock_i);
    exc_req_i[SL_MC] <= 1'b1;
    wait_take(got);
    chk(got && take_slot_o === 5'd1 && class_o === 4'b1000, "machine check");
    chk(machine_state_o === 32'h0 && fetch_addr_o === va(6'h01), "check state");
    chk(crit_save_state_o === 32'h0000_1800 && fp_prec_o === 2'b00, "check save");
    @(posedge clock_i);
    exc_req_i <= '0;
    @(posedge clock_i);
    rfci_i <= 1'b1;
    @(posedge clock_i);
    rfci_i <= 1'b0;
    #1;
    chk(machine_state_o === 32'h0000_1800 && fetch_addr_o === 32'h2000, "crit return");
    // Restored fp mode 10 makes the fp enabled exception imprecise
    @(posedge clock_i);
    fp_enabled_exc_i <= 1'b1;
    wait_take(got);
    chk(got && take_slot_o === 5'd6 && class_o === 4'b0001, "fp imprecise");
    @(posedge clock_i);
    fp_enabled_exc_i <= 1'b0;
  endtask

  // Main sequence: reset for 3 cycles, then each scenario in turn
  initial begin
    {nrst_i, fp_enabled_exc_i, rfi_i, rfci_i, ms_we_i, prefix_we_i, vo_we_i, go} = '0;
    {decrementer_int_enable_i, fixed_interval_int_enable_i, watchdog_int_enable_i} = '0;
    {internal_debug_mode_i, exc_req_i, dbg_evt_i, dbg_clr_i, syndrome_i} = '0;
    {next_pc_i, fault_pc_i, ms_wdata_i, prefix_i, vo_idx_i, vo_data_i} = '0;
    ce_i = 1'b1;
    hold = 1'b1;
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_setup();
    t_ext();
    t_dec();
    t_prio();
    t_crit();
    t_wdraw();
    t_syn();
    t_dbg();
    t_mc();
    print_verdict();
  end
endmodule // test_evd_core
